// [design/csvr_pkg.sv]
// Package: offsets, fields and reset values of the comparator status / reference registers
package csvr_pkg;
    localparam logic [15:0] VREF_CONTROL_OFF     = 16'h9600;
    localparam logic [15:0] CMP_STATUS_OFF       = 16'hA060;
    localparam logic [3:0]  ALIAS_BASE           = 4'h0;
    localparam logic [3:0]  ALIAS_CLR            = 4'h4;
    localparam logic [3:0]  ALIAS_SET            = 4'h8;
    localparam logic [3:0]  ALIAS_INV            = 4'hC;
    localparam int          STAT_IDLE_HALT_BIT   = 13;
    localparam int          STAT_CMP3_BIT        = 2;
    localparam int          STAT_CMP2_BIT        = 1;
    localparam int          STAT_CMP1_BIT        = 0;
    localparam int          VREF_ENABLE_BIT      = 15;
    localparam int          VREF_PIN_BIT         = 6;
    localparam int          VREF_RANGE_BIT       = 5;
    localparam int          VREF_SOURCE_BIT      = 4;
    localparam int          VREF_TAP_LSB         = 0;
    localparam int          VREF_TAP_WIDTH       = 4;
    localparam logic [31:0] STAT_WRITE_MASK      = 32'h0000_2000;
    localparam logic [31:0] VREF_WRITE_MASK      = 32'h0000_807F;
    localparam logic [31:0] STAT_RESET           = 32'h0000_0000;
    localparam logic [31:0] VREF_RESET           = 32'h0000_0000;
    localparam int          SYNC_STAGES          = 2;
    localparam int          CMP_COUNT            = 3;

    typedef enum logic [1:0]
    {
        CSVR_IDLE   = 2'b00,
        CSVR_SETUP  = 2'b01,
        CSVR_ACCESS = 2'b11
    } csvr_phase_t;
endpackage

// [design/csvr_regs.sv]
// Register file with base, clear, set and invert write paths
`timescale 1ns/1ps
module csvr_regs (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic [csvr_pkg::CMP_COUNT-1:0] cmp_sync,
    csvr_wr_if.regs   wr
);
    typedef struct packed
    {
        logic [31:0] vref;
        logic [31:0] stat;
    } csvr_regs_t;

    csvr_regs_t state_reg;
    csvr_regs_t state_next;

    function automatic logic [31:0] apply_op(
        input logic [31:0] cur,
        input logic [31:0] wd,
        input logic [3:0]  op,
        input logic [31:0] mask
    );
        logic [31:0] res;
        case (op)
            csvr_pkg::ALIAS_CLR: res = cur & ~wd;
            csvr_pkg::ALIAS_SET: res = cur | wd;
            csvr_pkg::ALIAS_INV: res = cur ^ wd;
            default:             res = wd;
        endcase
        // Unimplemented bits never store anything
        return res & mask;
    endfunction

    always_comb
    begin
        state_next = state_reg;
        if (wr.wr_stb && wr.sel_vref)
            state_next.vref = apply_op(state_reg.vref, wr.wdata, wr.alias_op,
                                       csvr_pkg::VREF_WRITE_MASK); // (RQ12)
        if (wr.wr_stb && wr.sel_stat)
            state_next.stat = apply_op(state_reg.stat, wr.wdata, wr.alias_op,
                                       csvr_pkg::STAT_WRITE_MASK); // (RQ5)
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_reg.vref <= csvr_pkg::VREF_RESET; // (RQ11)
            state_reg.stat <= csvr_pkg::STAT_RESET;
        end
        else
            state_reg <= state_next;
    end

    assign wr.vref_q = state_reg.vref;
    // Live comparator results merged into the read image only
    assign wr.stat_q = state_reg.stat
                     | {29'h0000_0000, cmp_sync}; // (RQ2) (RQ3) (RQ4)
endmodule

// [design/csvr_sync.sv]
// Two-stage synchroniser for the comparator result levels
`timescale 1ns/1ps
module csvr_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } csvr_sync_t;

    csvr_sync_t state_reg;
    csvr_sync_t state_next;

    always_comb
    begin
        state_next        = state_reg;
        state_next.meta   = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign sync_out = state_reg.stable;
endmodule

// [design/csvr_top.sv]
// Comparator status and voltage reference control registers behind an APB slave
//
// Contract
// (RQ1) Idle-halt bit set: all three comparators stop while the chip idles.
// (RQ2) Status bit 2 reads the live comparator three result.
// (RQ3) Status bit 1 reads the live comparator two result.
// (RQ4) Status bit 0 reads the live comparator one result.
// (RQ5) Other status bits read zero and ignore writes.
// (RQ6) Reference bit 15 enables the ladder; other bits untouched by it.
// (RQ7) Reference bit 6 connects the reference to its output pin.
// (RQ8) Reference bit 5 picks high span or quarter-based low range.
// (RQ9) Reference bit 4 picks external reference pins or analog supply.
// (RQ10) Reference bits 3..0 hold the ladder tap code 0..15.
// (RQ11) Unused reference bits read zero; implemented fields reset to zero.
// (RQ12) Offsets 0x4, 0x8, 0xC clear, set, toggle ones of base register.
// (RQ13) Software avoids access right after clearing the enable bit.
// (RQ14) Comparator results pass two flip-flops before the read path.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module csvr_top (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmp_one_result,
    input  wire logic        cmp_two_result,
    input  wire logic        cmp_three_result,
    input  wire logic        idle_mode,
    output logic             cmp_enable_allowed,
    output logic             ref_enable,
    output logic             ref_pin_connect,
    output logic             ref_range_select,
    output logic             ref_source_select,
    output logic      [3:0]  ref_tap_code
);
    typedef struct packed
    {
        csvr_pkg::csvr_phase_t phase;
        logic [31:0]           rdata;
        logic                  err;
        logic                  cmp_allow;
        logic                  en;
        logic                  pin;
        logic                  rng;
        logic                  src;
        logic [3:0]            tap;
    } csvr_top_t;

    csvr_top_t state_reg;
    csvr_top_t state_next;

    csvr_wr_if wr ();

    logic [csvr_pkg::CMP_COUNT-1:0] cmp_sync;
    logic [15:0]                    base_addr;
    logic                           hit_vref;
    logic                           hit_stat;
    logic                           access;

    csvr_sync #(
        .WIDTH (csvr_pkg::CMP_COUNT)
    ) u_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in ({cmp_three_result, cmp_two_result, cmp_one_result}), // (RQ14)
        .sync_out (cmp_sync)
    );

    csvr_regs u_regs (
        .mclk     (mclk),
        .reset    (reset),
        .cmp_sync (cmp_sync),
        .wr       (wr)
    );

    // Alias selects the operation; upper address bits pick the register
    assign base_addr = {paddr[15:4], 4'h0};
    assign hit_vref  = (base_addr == csvr_pkg::VREF_CONTROL_OFF) && (paddr[1:0] == 2'b00);
    assign hit_stat  = (base_addr == csvr_pkg::CMP_STATUS_OFF) && (paddr[1:0] == 2'b00);
    assign access    = psel && penable;

    assign wr.wr_stb   = access && pwrite && (pstrb == 4'hF);
    assign wr.sel_vref = hit_vref;
    assign wr.sel_stat = hit_stat;
    assign wr.alias_op = paddr[3:0]; // (RQ12)
    assign wr.wdata    = pwdata;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg.phase)
            csvr_pkg::CSVR_IDLE:
            begin
                if (psel && !penable)
                    state_next.phase = csvr_pkg::CSVR_SETUP;
            end
            csvr_pkg::CSVR_SETUP:
            begin
                state_next.phase = csvr_pkg::CSVR_ACCESS;
            end
            csvr_pkg::CSVR_ACCESS:
            begin
                state_next.phase = (psel && !penable) ? csvr_pkg::CSVR_SETUP
                                                      : csvr_pkg::CSVR_IDLE;
            end
            default:
            begin
                state_next.phase = csvr_pkg::CSVR_IDLE;
            end
        endcase

        // Read data staged in setup so it is valid through the access cycle
        if (psel && !penable)
        begin
            state_next.err   = !(hit_vref || hit_stat) || (pwrite && pstrb != 4'hF);
            state_next.rdata = 32'h0000_0000;
            if (!pwrite && hit_vref && paddr[3:0] == csvr_pkg::ALIAS_BASE)
                state_next.rdata = wr.vref_q; // (RQ11)
            else if (!pwrite && hit_stat && paddr[3:0] == csvr_pkg::ALIAS_BASE)
                state_next.rdata = wr.stat_q; // (RQ2) (RQ3) (RQ4) (RQ5)
        end

        // Idle halt gates the comparators only while idle is asserted
        state_next.cmp_allow = !(idle_mode
                                 && wr.stat_q[csvr_pkg::STAT_IDLE_HALT_BIT]); // (RQ1)
        state_next.en  = wr.vref_q[csvr_pkg::VREF_ENABLE_BIT]; // (RQ6)
        state_next.pin = wr.vref_q[csvr_pkg::VREF_PIN_BIT]; // (RQ7)
        state_next.rng = wr.vref_q[csvr_pkg::VREF_RANGE_BIT]; // (RQ8)
        state_next.src = wr.vref_q[csvr_pkg::VREF_SOURCE_BIT]; // (RQ9)
        state_next.tap = wr.vref_q[csvr_pkg::VREF_TAP_LSB +: csvr_pkg::VREF_TAP_WIDTH]; // (RQ10)
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_reg           <= '0;
            state_reg.phase     <= csvr_pkg::CSVR_IDLE;
            state_reg.cmp_allow <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    // Zero-wait slave: no stall needed, so the RQ13 hazard cannot hurt here
    assign pready             = 1'b1;
    assign prdata             = state_reg.rdata;
    assign pslverr            = access && state_reg.err;
    assign cmp_enable_allowed = state_reg.cmp_allow;
    assign ref_enable         = state_reg.en;
    assign ref_pin_connect    = state_reg.pin;
    assign ref_range_select   = state_reg.rng;
    assign ref_source_select  = state_reg.src;
    assign ref_tap_code       = state_reg.tap;
endmodule

// [design/csvr_wr_if.sv]
// Interface carrying a decoded register write between bus slave and register file
`timescale 1ns/1ps
interface csvr_wr_if;
    logic        wr_stb;
    logic        sel_vref;
    logic        sel_stat;
    logic [3:0]  alias_op;
    logic [31:0] wdata;
    logic [31:0] vref_q;
    logic [31:0] stat_q;

    modport slave
    (
        output wr_stb,
        output sel_vref,
        output sel_stat,
        output alias_op,
        output wdata,
        input  vref_q,
        input  stat_q
    );
    modport regs
    (
        input  wr_stb,
        input  sel_vref,
        input  sel_stat,
        input  alias_op,
        input  wdata,
        output vref_q,
        output stat_q
    );
endinterface

// [verif/csvr_assertions.sv]
// Checker for the comparator status and reference control registers
`timescale 1ns/1ps
module csvr_chk (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        cmp_one_result,
    input wire logic        cmp_two_result,
    input wire logic        cmp_three_result,
    input wire logic        idle_mode,
    input wire logic        cmp_enable_allowed,
    input wire logic        ref_enable,
    input wire logic        ref_pin_connect,
    input wire logic        ref_range_select,
    input wire logic        ref_source_select,
    input wire logic [3:0]  ref_tap_code
);
    localparam logic [15:0] VB = csvr_pkg::VREF_CONTROL_OFF;
    localparam logic [15:0] SB = csvr_pkg::CMP_STATUS_OFF;
    wire logic [7:0] ctl = {ref_enable, ref_pin_connect, ref_range_select,
                            ref_source_select, ref_tap_code};
    wire logic [7:0] wd  = {pwdata[15], pwdata[6:0]};
    wire logic [2:0] cmp = {cmp_three_result, cmp_two_result, cmp_one_result};
    wire logic       acc = psel && penable;
    wire logic       hit = (paddr[15:4] == VB[15:4] || paddr[15:4] == SB[15:4])
                           && paddr[1:0] == 2'h0;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_wr(logic [15:0] a);
        acc && pwrite && pstrb == 4'hF && paddr == a;
    endsequence
    sequence s_rd(logic [15:0] a);
        acc && !pwrite && paddr == a;
    endsequence
    // Synchroniser plus read staging needs a settled input
    sequence s_quiet;
        $stable(cmp)[*6];
    endsequence
    AST_IDLE_RUN: assert property (!idle_mode |=> cmp_enable_allowed)
        else $error("comparators stopped outside idle");
    AST_CMP_READ: assert property (s_quiet ##0 s_rd(SB) |-> prdata[2:0] == cmp)
        else $error("status result bits wrong");
    AST_STAT_ZERO: assert property (s_rd(SB) |-> (prdata & 32'hFFFF_DFF8) == 32'h0)
        else $error("status unused bits set");
    AST_VREF_ZERO: assert property (s_rd(VB) |-> (prdata & 32'hFFFF_7F80) == 32'h0)
        else $error("reference unused bits set");
    AST_CTL_BASE: assert property (s_wr(VB) |=> ##1 ctl == $past(wd, 2))
        else $error("reference outputs differ from write");
    AST_CTL_CLR: assert property (s_wr(VB | 16'h4) |=> ##1 ctl == ($past(ctl, 2) & ~$past(wd, 2)))
        else $error("clear alias wrong");
    AST_CTL_SET: assert property (s_wr(VB | 16'h8) |=> ##1 ctl == ($past(ctl, 2) | $past(wd, 2)))
        else $error("set alias wrong");
    AST_CTL_INV: assert property (s_wr(VB | 16'hC) |=> ##1 ctl == ($past(ctl, 2) ^ $past(wd, 2)))
        else $error("toggle alias wrong");
    AST_UNMAPPED: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    // Own disable so the reset cycles themselves are watched
    AST_RESET_VAL: assert property (disable iff (1'b0) reset |=> ctl == 8'h00 && cmp_enable_allowed && prdata == 32'h0)
        else $error("outputs not cleared by reset");
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the comparator status and reference registers
`timescale 1ns/1ps
module tb_top;
    localparam logic [15:0] VB = csvr_pkg::VREF_CONTROL_OFF;
    localparam logic [15:0] SB = csvr_pkg::CMP_STATUS_OFF;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [2:0]  cmp = 3'h0;
    logic        idle_mode = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cmp_enable_allowed;
    wire  [7:0]  ctl;
    logic [31:0] rd;
    logic        er;
    logic [31:0] vm;
    logic [31:0] sm;
    logic [31:0] d;
    logic [3:0]  op;
    int          fails = 0;
    int          num_checks = 0;
    always #25 mclk = ~mclk;
    csvr_top i_csvr_top (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .cmp_one_result(cmp[0]), .cmp_two_result(cmp[1]),
        .cmp_three_result(cmp[2]), .idle_mode, .cmp_enable_allowed, .ref_enable(ctl[7]),
        .ref_pin_connect(ctl[6]), .ref_range_select(ctl[5]), .ref_source_select(ctl[4]),
        .ref_tap_code(ctl[3:0]));
    task automatic conclude();
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Leaves psel up so a following call is a back-to-back setup
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd,
                        input logic [3:0] s);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        pstrb  <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            if (n > 16)
            begin
                fails++;
                conclude();
            end
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        penable <= 1'b0;
    endtask
    task automatic wt(input int n);
        psel <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask
    function automatic logic [31:0] upd(logic [31:0] c, logic [31:0] w, logic [3:0] o);
        case (o)
            4'h4:    return c & ~w;
            4'h8:    return c | w;
            4'hC:    return c ^ w;
            default: return w;
        endcase
    endfunction
    initial
    begin
        void'($urandom(50563));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        xfer(1'b0, VB, 32'h0, 4'hF);
        chk(rd, 32'h0);
        xfer(1'b0, SB, 32'h0, 4'hF);
        chk(rd, 32'h0);
        vm = 32'h0;
        for (int i = 0; i < 24; i++)
        begin
            d  = (i == 20) ? 32'hFFFF_FFFF : $urandom();
            op = (i < 4) ? 4'h0 : 4'(4 * (i % 4));
            xfer(1'b1, VB | {12'h0, op}, d, 4'hF);
            vm = upd(vm, d, op) & 32'h0000_807F;
            if (!vm[15])
                wt(1);
            xfer(1'b0, VB, 32'h0, 4'hF);
            chk(rd, vm);
            chk({24'h0, ctl}, {24'h0, vm[15], vm[6:0]});
        end
        xfer(1'b1, VB, 32'h0, 4'h3);
        chk({31'h0, er}, 32'h1);
        xfer(1'b0, VB | 16'h8, 32'h0, 4'hF);
        chk(rd, 32'h0);
        xfer(1'b0, VB, 32'h0, 4'hF);
        chk(rd, vm);
        xfer(1'b0, 16'h9610, 32'h0, 4'hF);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // Mid-run reset with every implemented reference field set
        xfer(1'b1, VB | 16'h8, 32'hFFFF_FFFF, 4'hF);
        reset <= 1'b1;
        wt(2);
        reset <= 1'b0;
        xfer(1'b0, VB, 32'h0, 4'hF);
        chk(rd, 32'h0);
        chk({24'h0, ctl}, 32'h0);
        sm = 32'h0;
        for (int i = 0; i < 16; i++)
        begin
            d  = (i == 0 || i == 10) ? 32'hFFFF_FFFF : $urandom();
            op = 4'(4 * (i % 4));
            cmp       <= 3'(i);
            idle_mode <= i[3];
            wt(5);
            xfer(1'b1, SB | {12'h0, op}, d, 4'hF);
            sm = upd(sm, d, op) & 32'h0000_2000;
            xfer(1'b0, SB, 32'h0, 4'hF);
            chk(rd, sm | 32'(i[2:0]));
            chk({31'h0, cmp_enable_allowed}, {31'h0, !(i[3] && sm[13])});
        end
        wt(2);
        conclude();
    end
endmodule
bind csvr_top csvr_chk i_csvr_chk (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pslverr, .cmp_one_result, .cmp_two_result,
    .cmp_three_result, .idle_mode, .cmp_enable_allowed, .ref_enable, .ref_pin_connect,
    .ref_range_select, .ref_source_select, .ref_tap_code);
